// >>> rtl/ai_alarm_cal_regs.vh
// register offsets, field positions and reset values
`ifndef AI_ALARM_CAL_REGS_VH
`define AI_ALARM_CAL_REGS_VH
`define ADDR_W 4
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_OFFSET 4'h2
`define REG_MEAS 4'h3
`define REG_DATA 4'h4
`define REG_ALM_LATCH 4'h5
`define REG_INT_STAT 4'h6
`define REG_INT_MASK 4'h7
`define REG_CAL_REF 4'h8
`define CTRL_EN_LSB 0
`define CTRL_CLR_LSB 5
`define CTRL_CAL_REQ 10
`define CTRL_LOW_TRIG 11
`define CTRL_HIGH_TRIG 12
`define CTRL_ALM_OFF 13
`define CTRL_CAL_CONN 14
`define CTRL_RESET 32'h0000_2000
`define ST_CALIBRATING 0
`define ST_GOOD_LOW 1
`define ST_BAD_LOW 2
`define ST_GOOD_HIGH 3
`define ST_BAD_HIGH 4
`define ST_CAL_FAIL 5
`define ST_CAL_OK 6
`define IRQ_ALARM_LSB 0
`define IRQ_CAL_OK 5
`define IRQ_CAL_FAIL 6
`define IRQ_W 7
`define OFFSET_RESET 32'h0000_0000
`endif

// >>> rtl/alarm_latch_bank.v
// per-alarm gating, latching and edge-triggered clearing
`timescale 1ns/1ps
`default_nettype none
module alarm_latch_bank #(
    parameter N = 5
) (
    input wire clk,
    input wire rst,
    input wire [N-1:0] raw_cond,
    input wire [N-1:0] enable,
    input wire alarms_off,
    input wire [N-1:0] clear_req,
    output wire [N-1:0] latched,
    output wire [N-1:0] set_pulse
);
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_alm
            // one flop pair per alarm, so each bit has a single process
            reg clear_d_r;
            reg latch_r;
            wire armed = enable[i] & ~alarms_off;
            wire rise = clear_req[i] & ~clear_d_r;
            wire set_now = armed & raw_cond[i];
            assign set_pulse[i] = set_now & ~latch_r;
            assign latched[i] = latch_r;
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    latch_r <= 1'b0;
                    clear_d_r <= 1'b0;
                end else begin
                    clear_d_r <= clear_req[i];
                    // set wins over a same-cycle clear; a held request
                    // clears nothing more after its edge
                    if (set_now)
                        latch_r <= 1'b1;
                    else if (rise)
                        latch_r <= 1'b0;
                    else if (~armed)
                        latch_r <= 1'b0;
                end
            end
        end
    endgenerate
endmodule // alarm_latch_bank
`default_nettype wire

// >>> rtl/analog_input_alarm_cal_ctrl.v
// channel alarm gating, field calibration sequencer and offset adder
//
// Notes on behaviour
// - each of the five alarms works only while its own enable bit is 1.
// - with the channel alarm-off bit at 1 no alarm works at all.
// - an alarm latch clears on a 0-to-1 edge of its clear request or when disarmed.
// - a calibrate request at 1 starts calibration and must stay high.
// - a calibrate request falling early aborts calibration.
// - a low trigger rising edge samples the low point of the range.
// - a high trigger rising edge samples the high point of the range.
// - the two triggers exist only with the calibration connection type.
// - the data result is measurement plus offset, offset resetting to 0.
// - an abort with a bad reference sampled sets the failure flag.
// - a good completion sets the success flag while connected.
`timescale 1ns/1ps
`default_nettype none
`include "ai_alarm_cal_regs.vh"
module analog_input_alarm_cal_ctrl #(
    parameter DW = 32,
    parameter REF_TOL = 32'h0000_0100
) (
    input wire REF_CLK,
    input wire RESET,
    input wire [`ADDR_W-1:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    input wire [DW-1:0] MEAS,
    input wire [DW-1:0] LOW_POINT,
    input wire [DW-1:0] HIGH_POINT,
    input wire [4:0] ALARM_COND,
    input wire CONN_OPEN,
    output reg [DW-1:0] DATA_OUT,
    output reg [4:0] ALARM_OUT,
    output reg CAL_ACTIVE,
    output reg IRQ
);
    // ---------------------------------------------------------------
    // state codes
    // ---------------------------------------------------------------
    localparam S_IDLE = 3'b001;
    localparam S_CAL = 3'b010;
    localparam S_DONE = 3'b100;

    function [DW-1:0] absdiff;
        input [DW-1:0] a;
        input [DW-1:0] b;
        begin
            absdiff = ($signed(a) > $signed(b)) ? a - b : b - a;
        end
    endfunction

    // one decoder for every write strobe keeps the map in a single place
    function reg_hit;
        input strobe;
        input [`ADDR_W-1:0] addr;
        input [`ADDR_W-1:0] index;
        begin
            reg_hit = strobe && addr == index;
        end
    endfunction

    // ---------------------------------------------------------------
    // registers and synchronisers
    // ---------------------------------------------------------------
    reg [31:0] ctrl_r;
    reg [DW-1:0] offset_r;
    reg [`IRQ_W-1:0] int_stat_r;
    reg [`IRQ_W-1:0] int_mask_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg good_low_r;
    reg bad_low_r;
    reg good_high_r;
    reg bad_high_r;
    reg cal_fail_r;
    reg cal_ok_r;
    reg low_d_r;
    reg high_d_r;
    reg [DW-1:0] low_cal_r;
    reg [DW-1:0] high_cal_r;
    reg conn_s1_r;
    reg conn_s2_r;
    reg [4:0] cond_s1_r;
    reg [4:0] cond_s2_r;
    wire [4:0] latched;
    wire [4:0] set_pulse;

    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            conn_s1_r <= 1'b0;
            conn_s2_r <= 1'b0;
            cond_s1_r <= 5'h00;
            cond_s2_r <= 5'h00;
        end else begin
            conn_s1_r <= CONN_OPEN;
            conn_s2_r <= conn_s1_r;
            cond_s1_r <= ALARM_COND;
            cond_s2_r <= cond_s1_r;
        end
    end

    // ---------------------------------------------------------------
    // alarms
    // ---------------------------------------------------------------
    alarm_latch_bank #(.N(5)) u_alarms (
        .clk(REF_CLK),
        .rst(RESET),
        .raw_cond(cond_s2_r),
        .enable(ctrl_r[`CTRL_EN_LSB+4:`CTRL_EN_LSB]),
        .alarms_off(ctrl_r[`CTRL_ALM_OFF]),
        .clear_req(ctrl_r[`CTRL_CLR_LSB+4:`CTRL_CLR_LSB]),
        .latched(latched),
        .set_pulse(set_pulse)
    );

    // ---------------------------------------------------------------
    // calibration sequencer
    // ---------------------------------------------------------------
    wire cal_req = ctrl_r[`CTRL_CAL_REQ];
    wire cal_conn = ctrl_r[`CTRL_CAL_CONN];
    // triggers are masked off with the plain connection type
    wire low_trig = ctrl_r[`CTRL_LOW_TRIG] & cal_conn;
    wire high_trig = ctrl_r[`CTRL_HIGH_TRIG] & cal_conn;
    wire low_rise = low_trig & ~low_d_r;
    wire high_rise = high_trig & ~high_d_r;
    // a reference is good only inside the tolerance window; a wider window
    // accepts noisier references at the cost of missing a wrong one
    wire low_ok = absdiff(MEAS, LOW_POINT) <= REF_TOL;
    wire high_ok = absdiff(MEAS, HIGH_POINT) <= REF_TOL;
    wire in_cal = (state_r == S_CAL);
    wire finish = in_cal & good_low_r & good_high_r;
    wire abort = in_cal & ~cal_req & ~finish;
    wire any_bad = bad_low_r | bad_high_r;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE:
                if (cal_req)
                    state_nxt = S_CAL;
            S_CAL:
                if (finish)
                    state_nxt = S_DONE;
                else if (~cal_req)
                    state_nxt = S_IDLE;
            S_DONE:
                if (~cal_req)
                    state_nxt = S_IDLE;
            default:
                state_nxt = S_IDLE;
        endcase
    end

    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            state_r <= S_IDLE;
            low_d_r <= 1'b0;
            high_d_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            // trigger history runs outside calibration too, so a trigger
            // already high at the start gives no edge
            low_d_r <= low_trig;
            high_d_r <= high_trig;
        end
    end

    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            good_low_r <= 1'b0;
            bad_low_r <= 1'b0;
            good_high_r <= 1'b0;
            bad_high_r <= 1'b0;
            low_cal_r <= {DW{1'b0}};
            high_cal_r <= {DW{1'b0}};
        end else begin
            if (state_r == S_IDLE && cal_req) begin
                good_low_r <= 1'b0;
                bad_low_r <= 1'b0;
                good_high_r <= 1'b0;
                bad_high_r <= 1'b0;
            end else if (in_cal) begin
                if (low_rise) begin
                    good_low_r <= low_ok;
                    bad_low_r <= ~low_ok;
                    if (low_ok)
                        low_cal_r <= MEAS;
                end
                if (high_rise) begin
                    good_high_r <= high_ok;
                    bad_high_r <= ~high_ok;
                    if (high_ok)
                        high_cal_r <= MEAS;
                end
            end
        end
    end

    // failure and success flags outlive the calibration that set them
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            cal_fail_r <= 1'b0;
            cal_ok_r <= 1'b0;
        end else begin
            if (abort && any_bad)
                cal_fail_r <= 1'b1;
            else if (finish)
                cal_fail_r <= 1'b0;
            // success holds only while the connection stays open
            if (~conn_s2_r)
                cal_ok_r <= 1'b0;
            else if (state_r == S_DONE && ~cal_req)
                cal_ok_r <= 1'b1;
            else if (state_r == S_IDLE && cal_req)
                cal_ok_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // interrupt status, set wins over write-one-to-clear
    // ---------------------------------------------------------------
    wire fail_ev = abort & any_bad;
    wire ok_ev = (state_r == S_DONE) & ~cal_req;
    reg [`IRQ_W-1:0] ev;

    always @* begin
        ev = {`IRQ_W{1'b0}};
        ev[`IRQ_ALARM_LSB+4:`IRQ_ALARM_LSB] = set_pulse;
        ev[`IRQ_CAL_OK] = ok_ev;
        ev[`IRQ_CAL_FAIL] = fail_ev;
    end

    wire wr_ctrl = reg_hit(WR, ADDR, `REG_CTRL);
    wire wr_off = reg_hit(WR, ADDR, `REG_OFFSET);
    wire wr_is = reg_hit(WR, ADDR, `REG_INT_STAT);
    wire wr_im = reg_hit(WR, ADDR, `REG_INT_MASK);

    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            ctrl_r <= `CTRL_RESET;
            offset_r <= `OFFSET_RESET;
            int_stat_r <= {`IRQ_W{1'b0}};
            int_mask_r <= {`IRQ_W{1'b0}};
        end else begin
            if (wr_ctrl)
                ctrl_r <= WDATA;
            if (wr_off)
                offset_r <= WDATA[DW-1:0];
            if (wr_im)
                int_mask_r <= WDATA[`IRQ_W-1:0];
            int_stat_r <= (int_stat_r & ~(wr_is ? WDATA[`IRQ_W-1:0]
                : {`IRQ_W{1'b0}})) | ev;
        end
    end

    // ---------------------------------------------------------------
    // read port and registered outputs
    // ---------------------------------------------------------------
    reg [31:0] status_w;

    // status is rebuilt every cycle from the live flags
    always @* begin
        status_w = 32'h0000_0000;
        status_w[`ST_CALIBRATING] = in_cal;
        status_w[`ST_GOOD_LOW] = good_low_r;
        status_w[`ST_BAD_LOW] = bad_low_r;
        status_w[`ST_GOOD_HIGH] = good_high_r;
        status_w[`ST_BAD_HIGH] = bad_high_r;
        status_w[`ST_CAL_FAIL] = cal_fail_r;
        status_w[`ST_CAL_OK] = cal_ok_r;
    end

    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            RDATA <= 32'h0000_0000;
            DATA_OUT <= {DW{1'b0}};
            ALARM_OUT <= 5'h00;
            CAL_ACTIVE <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            DATA_OUT <= MEAS + offset_r;
            ALARM_OUT <= latched;
            CAL_ACTIVE <= in_cal;
            IRQ <= |(int_stat_r & int_mask_r);
            RDATA <= 32'h0000_0000;
            if (RD) begin
                case (ADDR)
                    `REG_CTRL: RDATA <= ctrl_r;
                    `REG_STATUS: RDATA <= status_w;
                    `REG_OFFSET: RDATA <= offset_r;
                    `REG_MEAS: RDATA <= MEAS;
                    `REG_DATA: RDATA <= DATA_OUT;
                    `REG_ALM_LATCH: RDATA <= {27'h0, latched};
                    `REG_INT_STAT: RDATA <= {25'h0, int_stat_r};
                    `REG_INT_MASK: RDATA <= {25'h0, int_mask_r};
                    `REG_CAL_REF: RDATA <= high_cal_r - low_cal_r;
                    default: RDATA <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // analog_input_alarm_cal_ctrl
`default_nettype wire

// >>> tb/alarm_cal_checker_assertions.sv
// concurrent checks on the alarm and calibration controller ports
`timescale 1ns/1ps
`default_nettype none
`include "ai_alarm_cal_regs.vh"
module alarm_cal_checker #(parameter DW = 32) (
    input wire REF_CLK,
    input wire RESET,
    input wire [`ADDR_W-1:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [31:0] RDATA,
    input wire [DW-1:0] MEAS,
    input wire [4:0] ALARM_COND,
    input wire [DW-1:0] DATA_OUT,
    input wire [4:0] ALARM_OUT,
    input wire CAL_ACTIVE,
    input wire IRQ
);
    wire wr_ctrl = WR && ADDR == `REG_CTRL;
    wire wr_cal = wr_ctrl && WDATA[`CTRL_CAL_REQ];
    wire wr_off = WR && ADDR == `REG_OFFSET;
    wire rd_unmapped = RD && ADDR > `REG_CAL_REF;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    // ----------------------------------------------------------------
    // alarms
    // ----------------------------------------------------------------
    a_alarm_cause: assert property (
        !(|(ALARM_OUT & ~$past(ALARM_OUT)
        & ~($past(ALARM_COND, 2) | $past(ALARM_COND, 3)
        | $past(ALARM_COND, 4)))))
        else $error("alarm latched without its condition");
    a_alarm_hold: assert property (
        |(~ALARM_OUT & $past(ALARM_OUT))
        |-> $past(wr_ctrl) || $past(wr_ctrl, 2) || $past(wr_ctrl, 3))
        else $error("alarm dropped without a control write");
    // ----------------------------------------------------------------
    // calibration
    // ----------------------------------------------------------------
    a_cal_start: assert property ($rose(CAL_ACTIVE)
        |-> $past(wr_cal) || $past(wr_cal, 2) || $past(wr_cal, 3))
        else $error("calibration began without a request");
    a_cal_stop: assert property ($fell(CAL_ACTIVE)
        |-> $past(wr_ctrl) || $past(wr_ctrl, 2) || $past(wr_ctrl, 3)
        || $past(wr_ctrl, 4))
        else $error("calibration ended without a control write");
    // ----------------------------------------------------------------
    // data path and register bus
    // ----------------------------------------------------------------
    a_offset_sum: assert property (!$past(RESET) && !$past(RESET, 2)
        && !$past(wr_off, 2) |-> DATA_OUT - $past(MEAS)
        == $past(DATA_OUT) - $past(MEAS, 2))
        else $error("offset moved without an offset write");
    a_offset_zero: assert property ($fell(RESET)
        |-> ##2 DATA_OUT == $past(MEAS))
        else $error("offset not zero after reset");
    a_read_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data not zero outside a read");
    a_read_unmapped: assert property ($past(rd_unmapped)
        |-> RDATA == 32'h0) else $error("unmapped read not zero");
    c_alarm: cover property ($rose(|ALARM_OUT));
    c_cal: cover property ($rose(CAL_ACTIVE));
    c_irq: cover property ($rose(IRQ));
endmodule // alarm_cal_checker
bind analog_input_alarm_cal_ctrl alarm_cal_checker #(.DW(DW)) u_chk (
    .REF_CLK(REF_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .MEAS(MEAS),
    .ALARM_COND(ALARM_COND), .DATA_OUT(DATA_OUT),
    .ALARM_OUT(ALARM_OUT), .CAL_ACTIVE(CAL_ACTIVE), .IRQ(IRQ));
`default_nettype wire

// >>> tb/field_signal_model.sv
// field side model: measurement source and range reference points
`timescale 1ns/1ps
`default_nettype none
module field_signal_model #(parameter DW = 32) (
    input wire logic [1:0] sel,
    input wire logic [4:0] cond,
    input wire logic conn,
    output logic [DW-1:0] meas,
    output logic [DW-1:0] low_point,
    output logic [DW-1:0] high_point,
    output logic [4:0] alarm_cond,
    output logic conn_open
);
    assign low_point = 32'h0000_1000;
    assign high_point = 32'h0000_8000;
    assign alarm_cond = cond;
    assign conn_open = conn;
    // sel 3 misses the low point by far more than the reference tolerance
    assign meas = sel == 2'h1 ? low_point : sel == 2'h2 ? high_point :
        sel == 2'h3 ? low_point + 32'h0000_4000 : 32'h0000_0100;
endmodule // field_signal_model
`default_nettype wire

// >>> tb/analog_input_alarm_cal_ctrl_tb.sv
// self-checking bench for the alarm and calibration controller
`timescale 1ns/1ps
`default_nettype none
`include "ai_alarm_cal_regs.vh"
module analog_input_alarm_cal_ctrl_tb;
    logic REF_CLK = 1'b0;
    logic RESET = 1'b1;
    logic [3:0] ADDR = 4'h0;
    logic [31:0] WDATA = 32'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [4:0] cond = 5'h00;
    logic conn = 1'b1;
    logic [31:0] rv;
    wire [31:0] RDATA, MEAS, LOW_POINT, HIGH_POINT, DATA_OUT;
    wire [4:0] ALARM_COND, ALARM_OUT;
    wire CONN_OPEN, CAL_ACTIVE, IRQ;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    analog_input_alarm_cal_ctrl u_dut (.REF_CLK(REF_CLK), .RESET(RESET),
        .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .MEAS(MEAS), .LOW_POINT(LOW_POINT), .HIGH_POINT(HIGH_POINT),
        .ALARM_COND(ALARM_COND), .CONN_OPEN(CONN_OPEN),
        .DATA_OUT(DATA_OUT), .ALARM_OUT(ALARM_OUT),
        .CAL_ACTIVE(CAL_ACTIVE), .IRQ(IRQ));
    field_signal_model u_field (.sel(sel), .cond(cond), .conn(conn),
        .meas(MEAS), .low_point(LOW_POINT), .high_point(HIGH_POINT),
        .alarm_cond(ALARM_COND), .conn_open(CONN_OPEN));
    initial forever #10 REF_CLK = ~REF_CLK;
    // whole run needs well under 2000 cycles; a hang ends here
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // settle time covers the two-stage sync plus the latch and output flop
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge REF_CLK);
        WR <= 1'b0;
        repeat (6) @(posedge REF_CLK);
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge REF_CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1 rv = RDATA;
    endtask
    task automatic t_reset();
        rd(`REG_CTRL);
        check(rv, `CTRL_RESET);
        rd(`REG_OFFSET);
        check(rv, `OFFSET_RESET);
        rd(4'hf);
        check(rv, 32'h0);
        check({ALARM_OUT, CAL_ACTIVE, IRQ}, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_alarm();
        wr(`REG_INT_MASK, 32'h7f);
        cond <= 5'h1f;
        wr(`REG_CTRL, 32'h201f);
        check(ALARM_OUT, 5'h00);
        wr(`REG_CTRL, 32'h0005);
        check(ALARM_OUT, 5'h05);
        check(IRQ, 1'b1);
        wr(`REG_INT_MASK, 32'h0);
        check(IRQ, 1'b0);
        wr(`REG_INT_MASK, 32'h7f);
        cond <= 5'h00;
        wr(`REG_CTRL, 32'h0025);
        check(ALARM_OUT, 5'h04);
        rd(`REG_ALM_LATCH);
        check(rv, 32'h4);
        cond <= 5'h01;
        wr(`REG_CTRL, 32'h0025);
        cond <= 5'h00;
        wr(`REG_CTRL, 32'h0065);
        check(ALARM_OUT, 5'h05);
        wr(`REG_INT_STAT, 32'h7f);
        check(IRQ, 1'b0);
        wr(`REG_CTRL, 32'h2000);
        $display("test alarm done");
    endtask
    task automatic t_offset();
        wr(`REG_OFFSET, 32'h10);
        check(DATA_OUT, 32'h110);
        rd(`REG_DATA);
        check(rv, 32'h110);
        $display("test offset done");
    endtask
    task automatic t_cal_good();
        wr(`REG_CTRL, 32'h6400);
        check(CAL_ACTIVE, 1'b1);
        sel <= 2'h1;
        wr(`REG_CTRL, 32'h6c00);
        rd(`REG_STATUS);
        check(rv & 32'h1e, 32'h02);
        sel <= 2'h2;
        wr(`REG_CTRL, 32'h7400);
        rd(`REG_STATUS);
        check(rv & 32'h1e, 32'h0a);
        wr(`REG_CTRL, 32'h6000);
        rd(`REG_STATUS);
        check(rv & 32'h61, 32'h40);
        rd(`REG_CAL_REF);
        check(rv, 32'h7000);
        conn <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        rd(`REG_STATUS);
        check(rv & 32'h40, 32'h00);
        conn <= 1'b1;
        $display("test cal good done");
    endtask
    task automatic t_cal_bad();
        wr(`REG_CTRL, 32'h2400);
        wr(`REG_CTRL, 32'h2c00);
        rd(`REG_STATUS);
        check(rv & 32'h1e, 32'h00);
        sel <= 2'h3;
        wr(`REG_CTRL, 32'h6400);
        wr(`REG_CTRL, 32'h6c00);
        rd(`REG_STATUS);
        check(rv & 32'h1e, 32'h04);
        wr(`REG_CTRL, 32'h6000);
        rd(`REG_STATUS);
        check(rv & 32'h61, 32'h20);
        check(CAL_ACTIVE, 1'b0);
        $display("test cal bad done");
    endtask
    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge REF_CLK);
        RESET <= 1'b0;
        t_reset();
        t_alarm();
        t_offset();
        t_cal_good();
        t_cal_bad();
        complete_run();
    end
endmodule // analog_input_alarm_cal_ctrl_tb
`default_nettype wire
